// ### exec_pkg.sv
// Constants and types for the logic, compare, rotate and status-byte execution block.
// Assumes one processor clock; one machine cycle equals CLK_PER_CYCLE clock periods.
package exec_pkg;

  localparam int NUM_REGS      = 7;
  localparam int ADDR_W        = 15;
  localparam int CLK_PER_CYCLE = 3;

  // Execution times in machine cycles
  localparam int CYC_SHORT     = 2;
  localparam int CYC_RELATIVE  = 3;
  localparam int CYC_ABSOLUTE  = 4;
  localparam int CYC_INDIRECT  = 2;

  // Clock counts derived from machine cycles
  localparam int CLK_SHORT     = CYC_SHORT * CLK_PER_CYCLE;
  localparam int CLK_RELATIVE  = CYC_RELATIVE * CLK_PER_CYCLE;
  localparam int CLK_ABSOLUTE  = CYC_ABSOLUTE * CLK_PER_CYCLE;
  localparam int CLK_INDIRECT  = CYC_INDIRECT * CLK_PER_CYCLE;

  // Opcode classes, bits 7..2 of the first byte
  localparam logic [5:0] CLS_XOR_RELATIVE = 6'h0a;
  localparam logic [5:0] CLS_XOR_ABSOLUTE = 6'h0b;
  localparam logic [5:0] CLS_CMP_REG_ZERO = 6'h38;
  localparam logic [5:0] CLS_CMP_IMM      = 6'h39;
  localparam logic [5:0] CLS_CMP_RELATIVE = 6'h3a;
  localparam logic [5:0] CLS_CMP_ABSOLUTE = 6'h3b;
  localparam logic [5:0] CLS_ROTATE_LEFT  = 6'h34;
  localparam logic [5:0] CLS_ROTATE_RIGHT = 6'h14;

  // Whole one-byte status opcodes
  localparam logic [7:0] OPC_LOAD_UPPER   = 8'h92;
  localparam logic [7:0] OPC_LOAD_LOWER   = 8'h93;
  localparam logic [7:0] OPC_STORE_UPPER  = 8'h12;
  localparam logic [7:0] OPC_STORE_LOWER  = 8'h13;

  // Second-byte address field positions
  localparam int ADR_INDIRECT_BIT = 7;
  localparam int ADR_INDEX_HI     = 6;
  localparam int ADR_INDEX_LO     = 5;

  // Lower status byte field positions
  localparam int PSL_CC_HI = 7;
  localparam int PSL_CC_LO = 6;
  localparam int PSL_IDC   = 5;
  localparam int PSL_RS    = 4;
  localparam int PSL_WC    = 3;
  localparam int PSL_OVF   = 2;
  localparam int PSL_COM   = 1;
  localparam int PSL_C     = 0;

  localparam logic [7:0] PSU_UNUSED_MASK = 8'h18;
  localparam logic [7:0] PSU_RESET       = 8'h00;
  localparam logic [7:0] PSL_RESET       = 8'h00;
  localparam logic [7:0] REG_RESET       = 8'h00;

  localparam logic [1:0] CC_POS  = 2'h1;
  localparam logic [1:0] CC_ZERO = 2'h0;
  localparam logic [1:0] CC_NEG  = 2'h2;

  typedef enum logic [3:0] {
    OP_NONE, OP_XOR, OP_CMP, OP_ROL, OP_ROR, OP_LOAD_UPPER, OP_LOAD_LOWER, OP_STORE_UPPER, OP_STORE_LOWER
  } op_kind_t;

  typedef logic [NUM_REGS-1:0][7:0] reg_array_t;

endpackage

// ### exec_if.sv
// Carries operands, results and register writes between the sequencer, ALU and register bank.
// Assumes all three modules share one clock.
`timescale 1ns/1ps
interface exec_if;
  exec_pkg::op_kind_t   kind;
  logic [7:0]           a;
  logic [7:0]           b;
  logic [7:0]           psl_in;
  logic [7:0]           res;
  logic [7:0]           psl_out;
  logic                 wr_en;
  logic [2:0]           wr_idx;
  logic [7:0]           wr_data;
  exec_pkg::reg_array_t regs;

  modport ctl  (output kind, a, b, psl_in, wr_en, wr_idx, wr_data, input res, psl_out, regs);
  modport alu  (input kind, a, b, psl_in, output res, psl_out);
  modport bank (input wr_en, wr_idx, wr_data, output regs);
endinterface

// ### exec_alu.sv
// Combinational ALU: exclusive OR, compare, rotates and status transfers.
// Assumes the sequencer holds operands stable while it uses the result.
`timescale 1ns/1ps
module exec_alu (
  exec_if.alu x
);

  function automatic logic [1:0] sign_cc(input logic [7:0] v);
    if (v[7])
      return exec_pkg::CC_NEG;
    else if (v == 8'h00)
      return exec_pkg::CC_ZERO;
    else
      return exec_pkg::CC_POS;
  endfunction

  logic gt;
  logic [1:0] cmp_cc;

  always_comb
  begin
    gt = x.psl_in[exec_pkg::PSL_COM] ? (x.a > x.b) : ($signed(x.a) > $signed(x.b)); // RULE5
    if (gt)
      cmp_cc = exec_pkg::CC_POS; // RULE6 RULE9
    else if (x.a == x.b)
      cmp_cc = exec_pkg::CC_ZERO;
    else
      cmp_cc = exec_pkg::CC_NEG;
  end

  always_comb
  begin
    x.res = x.a;
    x.psl_out = x.psl_in;
    case (x.kind)
      exec_pkg::OP_XOR:
      begin
        x.res = x.a ^ x.b; // RULE1 RULE2
        x.psl_out[exec_pkg::PSL_CC_HI:exec_pkg::PSL_CC_LO] = sign_cc(x.a ^ x.b); // RULE19
      end
      exec_pkg::OP_CMP:
        x.psl_out[exec_pkg::PSL_CC_HI:exec_pkg::PSL_CC_LO] = cmp_cc; // RULE7 RULE8
      exec_pkg::OP_ROL:
      begin
        if (x.psl_in[exec_pkg::PSL_WC])
        begin
          x.res = {x.a[6:0], x.psl_in[exec_pkg::PSL_C]}; // RULE10
          x.psl_out[exec_pkg::PSL_C] = x.a[7];
          x.psl_out[exec_pkg::PSL_IDC] = x.a[4]; // RULE11
        end
        else
          x.res = {x.a[6:0], x.a[7]}; // RULE10
        if (x.res[7] != x.a[7])
          x.psl_out[exec_pkg::PSL_OVF] = 1'b1; // RULE14
        x.psl_out[exec_pkg::PSL_CC_HI:exec_pkg::PSL_CC_LO] = sign_cc(x.res);
      end
      exec_pkg::OP_ROR:
      begin
        if (x.psl_in[exec_pkg::PSL_WC])
        begin
          x.res = {x.psl_in[exec_pkg::PSL_C], x.a[7:1]}; // RULE12
          x.psl_out[exec_pkg::PSL_C] = x.a[0];
          x.psl_out[exec_pkg::PSL_IDC] = x.a[6]; // RULE13
        end
        else
          x.res = {x.a[0], x.a[7:1]}; // RULE12
        if (x.res[7] != x.a[7])
          x.psl_out[exec_pkg::PSL_OVF] = 1'b1; // RULE14
        x.psl_out[exec_pkg::PSL_CC_HI:exec_pkg::PSL_CC_LO] = sign_cc(x.res);
      end
      exec_pkg::OP_LOAD_LOWER:
        x.psl_out = x.a; // RULE16
      exec_pkg::OP_STORE_UPPER, exec_pkg::OP_STORE_LOWER:
        x.psl_out[exec_pkg::PSL_CC_HI:exec_pkg::PSL_CC_LO] = sign_cc(x.a); // RULE17 RULE18
      default:
        x.res = x.a;
    endcase
  end

endmodule

// ### exec_reg_bank.sv
// General register bank: register zero plus two banks of three, held in flip-flops.
// Assumes the sequencer has write priority over the external load port.
`timescale 1ns/1ps
module exec_reg_bank (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       ext_wr,
  input  wire logic [2:0] ext_idx,
  input  wire logic [7:0] ext_data,
  exec_if.bank            x
);

  typedef struct packed {
    exec_pkg::reg_array_t regs;
  } bank_state_t;

  bank_state_t s_r;
  bank_state_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (x.wr_en)
      s_nxt.regs[x.wr_idx] = x.wr_data;
    else if (ext_wr && ext_idx < 3'(exec_pkg::NUM_REGS))
      s_nxt.regs[ext_idx] = ext_data;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      s_r <= '{regs: {exec_pkg::NUM_REGS{exec_pkg::REG_RESET}}};
    else
      s_r <= s_nxt;
  end

  assign x.regs = s_r.regs;

endmodule

// ### exec_unit.sv
// Sequencer for exclusive OR, compare, rotate and status-byte load/store instructions.
// Assumes shared address logic supplies the effective address with start, and memory acks reads.
//
// Behaviour
// RULE1: relative XOR writes register XOR memory byte back into that register.
// RULE2: absolute XOR replaces register with XOR result; four machine cycles.
// RULE3: indexed absolute forms name index by opcode low bits; destination becomes register zero.
// RULE4: relative forms accept indirect addressing from the address byte.
// RULE5: compare is unsigned when compare mode is one, signed otherwise.
// RULE6: register-zero compare sets code 01 greater, 00 equal, 10 less only.
// RULE7: immediate compare uses second byte, two cycles, changes only the code.
// RULE8: relative and absolute compares use memory byte, change only the code.
// RULE9: absolute compare sets 01, 00, 10 by magnitude; four cycles.
// RULE10: rotate left wraps bit 7, or goes through carry when with-carry set.
// RULE11: rotate left through carry copies bit 4 into interdigit carry.
// RULE12: rotate right wraps bit 0, or goes through carry when with-carry set.
// RULE13: rotate right through carry copies bit 6 into interdigit carry.
// RULE14: rotate changing bit 7 sets overflow; rotates take two cycles.
// RULE15: load upper status takes register zero, unassigned bits 4 and 3 zero.
// RULE16: load lower status takes register zero, code from its bits 7 and 6.
// RULE17: store upper status copies it to register zero, code from sign/zero.
// RULE18: store lower status copies it to register zero, code from sign/zero.
// RULE19: XOR sets code from result: 01 positive, 00 zero, 10 negative.
// RULE20: effective address comes from shared address logic before the operand read.
`timescale 1ns/1ps
module exec_unit (
  input  wire logic                        clock,
  input  wire logic                        resetn,
  input  wire logic                        start,
  input  wire logic [7:0]                  opcode,
  input  wire logic [7:0]                  byte1,
  input  wire logic [exec_pkg::ADDR_W-1:0] ea,
  output logic                             mem_rd_r,
  output logic [exec_pkg::ADDR_W-1:0]      mem_addr_r,
  input  wire logic                        mem_ack,
  input  wire logic [7:0]                  mem_rdata,
  input  wire logic                        ext_wr,
  input  wire logic [2:0]                  ext_idx,
  input  wire logic [7:0]                  ext_data,
  output logic [7:0]                       index_value_r,
  output logic [7:0]                       psu_r,
  output logic [7:0]                       psl_r,
  output logic                             busy_r,
  output logic                             done_r,
  output logic                             unknown_r,
  output exec_pkg::reg_array_t             regs_r
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WAIT = 3'b100
  } state_t;

  typedef struct packed {
    state_t                        state;
    exec_pkg::op_kind_t            kind;
    logic [2:0]                    a_idx;
    logic [2:0]                    b_idx;
    logic                          b_from_reg;
    logic [7:0]                    operand;
    logic [4:0]                    cnt;
    logic [4:0]                    total;
    logic                          mem_rd;
    logic [exec_pkg::ADDR_W-1:0]   mem_addr;
    logic [7:0]                    index_value;
    logic [7:0]                    upper_status_byte;
    logic [7:0]                    lower_status_byte;
    logic                          busy;
    logic                          done;
    logic                          unknown;
  } unit_state_t;

  unit_state_t s_r;
  unit_state_t s_nxt;

  exec_if x ();

  exec_alu u_alu (
    .x (x.alu)
  );

  exec_reg_bank u_bank (
    .clock    (clock),
    .resetn   (resetn),
    .ext_wr   (ext_wr),
    .ext_idx  (ext_idx),
    .ext_data (ext_data),
    .x        (x.bank)
  );

  // Register one maps to one or four by the bank select
  function automatic logic [2:0] phys(input logic [1:0] r, input logic rs);
    if (r == 2'd0)
      return 3'd0;
    else if (rs)
      return 3'({1'b0, r} + 3'd3);
    else
      return {1'b0, r};
  endfunction

  logic [5:0] cls;
  logic [1:0] rsel;
  logic       rs;
  logic       indirect;
  logic       indexed;
  logic       finish;
  logic [4:0] extra;

  always_comb
  begin
    cls = opcode[7:2];
    rsel = opcode[1:0];
    rs = s_r.lower_status_byte[exec_pkg::PSL_RS];
    indirect = byte1[exec_pkg::ADR_INDIRECT_BIT];
    indexed = |byte1[exec_pkg::ADR_INDEX_HI:exec_pkg::ADR_INDEX_LO];
    extra = indirect ? 5'(exec_pkg::CLK_INDIRECT) : 5'd0; // RULE4
    finish = (s_r.state == ST_WAIT) && (s_r.cnt >= s_r.total - 5'd1);
  end

  // Operands to the ALU
  always_comb
  begin
    x.kind = s_r.kind;
    x.psl_in = s_r.lower_status_byte;
    case (s_r.kind)
      exec_pkg::OP_STORE_UPPER:
        x.a = s_r.upper_status_byte & ~exec_pkg::PSU_UNUSED_MASK; // RULE17
      exec_pkg::OP_STORE_LOWER:
        x.a = s_r.lower_status_byte; // RULE18
      default:
        x.a = x.regs[s_r.a_idx];
    endcase
    x.b = s_r.b_from_reg ? x.regs[s_r.b_idx] : s_r.operand;
  end

  // Write-back, only on the final clock of the instruction
  always_comb
  begin
    x.wr_en = 1'b0;
    x.wr_idx = s_r.a_idx;
    x.wr_data = x.res;
    if (finish)
    begin
      case (s_r.kind)
        exec_pkg::OP_XOR, exec_pkg::OP_ROL, exec_pkg::OP_ROR:
          x.wr_en = 1'b1; // RULE1 RULE2
        exec_pkg::OP_STORE_UPPER, exec_pkg::OP_STORE_LOWER:
        begin
          x.wr_en = 1'b1;
          x.wr_idx = 3'd0;
        end
        default:
          x.wr_en = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.unknown = 1'b0;
    // Tracks the index register through a flip-flop, so it lags a register write by one clock
    s_nxt.index_value = x.regs[phys(rsel, rs)]; // RULE3 RULE20
    case (s_r.state)
      ST_IDLE:
      begin
        if (start)
        begin
          s_nxt.cnt = 5'd0;
          s_nxt.busy = 1'b1;
          s_nxt.a_idx = phys(rsel, rs);
          s_nxt.b_idx = 3'd0;
          s_nxt.b_from_reg = 1'b0;
          s_nxt.operand = byte1;
          s_nxt.mem_addr = ea; // RULE20
          s_nxt.kind = exec_pkg::OP_NONE;
          s_nxt.total = 5'(exec_pkg::CLK_SHORT);
          s_nxt.state = ST_WAIT;
          if (opcode == exec_pkg::OPC_LOAD_UPPER)
            s_nxt.kind = exec_pkg::OP_LOAD_UPPER;
          else if (opcode == exec_pkg::OPC_LOAD_LOWER)
          begin
            s_nxt.kind = exec_pkg::OP_LOAD_LOWER;
            s_nxt.a_idx = 3'd0;
          end
          else if (opcode == exec_pkg::OPC_STORE_UPPER)
            s_nxt.kind = exec_pkg::OP_STORE_UPPER;
          else if (opcode == exec_pkg::OPC_STORE_LOWER)
            s_nxt.kind = exec_pkg::OP_STORE_LOWER;
          else
          begin
            case (cls)
              exec_pkg::CLS_XOR_RELATIVE, exec_pkg::CLS_CMP_RELATIVE:
              begin
                s_nxt.kind = (cls == exec_pkg::CLS_XOR_RELATIVE) ? exec_pkg::OP_XOR : exec_pkg::OP_CMP;
                s_nxt.total = 5'(exec_pkg::CLK_RELATIVE) + extra; // RULE4
                s_nxt.state = ST_READ;
              end
              exec_pkg::CLS_XOR_ABSOLUTE, exec_pkg::CLS_CMP_ABSOLUTE:
              begin
                s_nxt.kind = (cls == exec_pkg::CLS_XOR_ABSOLUTE) ? exec_pkg::OP_XOR : exec_pkg::OP_CMP;
                s_nxt.total = 5'(exec_pkg::CLK_ABSOLUTE) + extra; // RULE2 RULE9
                if (indexed)
                  s_nxt.a_idx = 3'd0; // RULE3
                s_nxt.state = ST_READ;
              end
              exec_pkg::CLS_CMP_REG_ZERO:
              begin
                s_nxt.kind = exec_pkg::OP_CMP;
                s_nxt.a_idx = 3'd0; // RULE6
                s_nxt.b_idx = phys(rsel, rs);
                s_nxt.b_from_reg = 1'b1;
              end
              exec_pkg::CLS_CMP_IMM:
                s_nxt.kind = exec_pkg::OP_CMP; // RULE7
              exec_pkg::CLS_ROTATE_LEFT:
                s_nxt.kind = exec_pkg::OP_ROL; // RULE14
              exec_pkg::CLS_ROTATE_RIGHT:
                s_nxt.kind = exec_pkg::OP_ROR; // RULE14
              default:
              begin
                // Opcodes outside this block finish at once and change nothing
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
                s_nxt.unknown = 1'b1;
                s_nxt.state = ST_IDLE;
              end
            endcase
          end
          s_nxt.mem_rd = (s_nxt.state == ST_READ);
        end
      end
      ST_READ:
      begin
        s_nxt.cnt = s_r.cnt + 5'd1;
        if (mem_ack)
        begin
          s_nxt.operand = mem_rdata; // RULE8
          s_nxt.mem_rd = 1'b0;
          s_nxt.state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        // Memory wait clocks count toward the nominal time; only a read lasting past it stretches the instruction
        s_nxt.cnt = s_r.cnt + 5'd1;
        if (finish)
        begin
          if (s_r.kind == exec_pkg::OP_LOAD_UPPER)
            s_nxt.upper_status_byte = x.regs[0] & ~exec_pkg::PSU_UNUSED_MASK; // RULE15
          else
            s_nxt.lower_status_byte = x.psl_out; // RULE6 RULE8 RULE16
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.state = ST_IDLE;
        end
      end
      default:
        s_nxt.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      s_r <= '0;
      s_r.state <= ST_IDLE;
      s_r.kind <= exec_pkg::OP_NONE;
      s_r.upper_status_byte <= exec_pkg::PSU_RESET;
      s_r.lower_status_byte <= exec_pkg::PSL_RESET;
    end
    else
      s_r <= s_nxt;
  end

  assign mem_rd_r = s_r.mem_rd;
  assign mem_addr_r = s_r.mem_addr;
  assign index_value_r = s_r.index_value;
  assign psu_r = s_r.upper_status_byte;
  assign psl_r = s_r.lower_status_byte;
  assign busy_r = s_r.busy;
  assign done_r = s_r.done;
  assign unknown_r = s_r.unknown;
  assign regs_r = x.regs;

endmodule

// ### exec_unit_assertions.sv
// Concurrent checks on the ports of the execution block.
// Assumes ext_wr stays low while an instruction is in flight.
`timescale 1ns/1ps
module exec_unit_assertions (
  input wire logic                        clock,
  input wire logic                        resetn,
  input wire logic                        start,
  input wire logic [7:0]                  opcode,
  input wire logic [7:0]                  byte1,
  input wire logic [exec_pkg::ADDR_W-1:0] ea,
  input wire logic                        mem_rd_r,
  input wire logic [exec_pkg::ADDR_W-1:0] mem_addr_r,
  input wire logic                        mem_ack,
  input wire logic [7:0]                  psu_r,
  input wire logic [7:0]                  psl_r,
  input wire logic                        busy_r,
  input wire logic                        done_r,
  input wire logic                        unknown_r,
  input wire exec_pkg::reg_array_t        regs_r
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic       go;
  logic [5:0] cls;
  logic       rel_op;
  logic       abs_op;
  assign go     = start && !busy_r;
  assign cls    = opcode[7:2];
  assign rel_op = cls == exec_pkg::CLS_XOR_RELATIVE || cls == exec_pkg::CLS_CMP_RELATIVE;
  assign abs_op = cls == exec_pkg::CLS_XOR_ABSOLUTE || cls == exec_pkg::CLS_CMP_ABSOLUTE;
  sequence s_quiet6;
    (!done_r && $stable(regs_r) && $stable(psu_r))[*6];
  endsequence
  sequence s_code_only;
    done_r && $stable(regs_r) && $stable(psu_r) && $stable(psl_r[5:0]);
  endsequence
  a_rotate_timing: assert property (go && (cls == exec_pkg::CLS_ROTATE_LEFT || cls == exec_pkg::CLS_ROTATE_RIGHT)
    |=> (!done_r)[*6] ##1 done_r) else $error("rotate not done in six clocks");
  a_cmp_code_only: assert property (go && (cls == exec_pkg::CLS_CMP_REG_ZERO || cls == exec_pkg::CLS_CMP_IMM)
    |=> s_quiet6 ##1 s_code_only) else $error("short compare timing or side effect");
  a_abs_timing: assert property (go && abs_op && !byte1[7] |-> ##13 done_r)
    else $error("absolute form not done in twelve clocks");
  a_rel_indirect: assert property (go && rel_op && byte1[7] |-> ##16 done_r)
    else $error("indirect relative form timing");
  a_mem_request: assert property (go && (rel_op || abs_op) |=> mem_rd_r && mem_addr_r == $past(ea))
    else $error("memory read not issued at effective address");
  a_mem_hold: assert property (mem_rd_r && !mem_ack |=> mem_rd_r && $stable(mem_addr_r))
    else $error("memory read dropped before answer");
  a_upper_load: assert property (go && opcode == exec_pkg::OPC_LOAD_UPPER
    |-> ##7 (done_r && psu_r == ($past(regs_r[0], 6) & ~exec_pkg::PSU_UNUSED_MASK)))
    else $error("upper status load wrong");
  a_lower_load: assert property (go && opcode == exec_pkg::OPC_LOAD_LOWER |-> ##7 (done_r && psl_r == $past(regs_r[0], 6)))
    else $error("lower status load wrong");
  a_unknown_done: assert property (go && opcode == 8'h00 |=> done_r && unknown_r && !busy_r)
    else $error("unknown opcode not retired at once");
endmodule

bind exec_unit exec_unit_assertions chk (.clock(clock), .resetn(resetn), .start(start), .opcode(opcode),
  .byte1(byte1), .ea(ea), .mem_rd_r(mem_rd_r), .mem_addr_r(mem_addr_r), .mem_ack(mem_ack), .psu_r(psu_r),
  .psl_r(psl_r), .busy_r(busy_r), .done_r(done_r), .unknown_r(unknown_r), .regs_r(regs_r));

// ### mem_model.sv
// Operand memory answering the block's reads, promptly or two clocks late.
// Assumes byte at address a is a[7:0] xor a[14:8]; released data shows the inverse.
`timescale 1ns/1ps
module mem_model (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        mem_rd_r,
  input  wire logic [14:0] mem_addr_r,
  input  wire logic        slow,
  output logic             mem_ack,
  output logic [7:0]       mem_rdata
);
  logic [1:0] wait_r;
  logic [7:0] last_r;
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
    begin
      wait_r <= 2'h0;
      last_r <= 8'h00;
    end
    else
    begin
      wait_r <= (mem_rd_r && !mem_ack) ? wait_r + 2'h1 : 2'h0;
      if (mem_ack)
        last_r <= mem_rdata;
    end
  assign mem_ack   = mem_rd_r && (wait_r >= (slow ? 2'h2 : 2'h0));
  // Inverse when idle, so a stale sample never looks right
  assign mem_rdata = mem_ack ? (mem_addr_r[7:0] ^ {1'b0, mem_addr_r[14:8]}) : ~last_r;
endmodule

// ### xor_compare_rotate_psw_exec_tb.sv
// Self-checking bench: shadow model notes expected state, monitor compares at each retirement.
// Assumes mem_model answers reads; design opcodes as in exec_pkg.
`timescale 1ns/1ps
module xor_compare_rotate_psw_exec_tb;
  typedef struct {exec_pkg::reg_array_t regs; logic [7:0] upper_status_byte; logic [7:0] lower_status_byte; int when; logic unk;} note_t;
  logic clock = 0, resetn = 0, start = 0, ext_wr = 0, slow = 0, mem_rd_r, mem_ack, busy_r, done_r, unknown_r;
  logic [7:0] opcode = 0, byte1 = 0, ext_data = 0, mem_rdata, index_value_r, psu_r, psl_r;
  logic [2:0] ext_idx = 0;
  logic [14:0] ea = 0, mem_addr_r;
  exec_pkg::reg_array_t regs_r, ex_regs = '0;
  logic [7:0] ex_psu = 0, ex_psl = 0;
  int miscompares = 0, total_checks = 0, cyc = 0;
  note_t q[$];
  logic [7:0] ops[13] = '{8'h28, 8'h2c, 8'he0, 8'he4, 8'he8, 8'hec, 8'hd0, 8'h50, 8'h92, 8'h12, 8'h13, 8'h93, 8'h00};
  always #4 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  exec_unit dut (.clock(clock), .resetn(resetn), .start(start), .opcode(opcode), .byte1(byte1), .ea(ea),
    .mem_rd_r(mem_rd_r), .mem_addr_r(mem_addr_r), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ext_wr(ext_wr),
    .ext_idx(ext_idx), .ext_data(ext_data), .index_value_r(index_value_r), .psu_r(psu_r), .psl_r(psl_r),
    .busy_r(busy_r), .done_r(done_r), .unknown_r(unknown_r), .regs_r(regs_r));
  mem_model mem (.clock(clock), .resetn(resetn), .mem_rd_r(mem_rd_r), .mem_addr_r(mem_addr_r), .slow(slow),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (exp !== got)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [1:0] cc_of(input logic [7:0] v);
    return (v == 8'h00) ? exec_pkg::CC_ZERO : (v[7] ? exec_pkg::CC_NEG : exec_pkg::CC_POS);
  endfunction
  function automatic logic [1:0] cmp_cc(input logic [7:0] a, input logic [7:0] b, input logic uns);
    if (a == b)
      return exec_pkg::CC_ZERO;
    if (uns ? (a > b) : ($signed(a) > $signed(b)))
      return exec_pkg::CC_POS;
    return exec_pkg::CC_NEG;
  endfunction
  always @(negedge clock)
    if (resetn && done_r === 1'b1)
    begin
      if (q.size() == 0)
        chk("spare done", 0, 1);
      else
      begin
        chk("done time", q[0].when, cyc);
        chk("regs", q[0].regs, regs_r);
        chk("psl", q[0].lower_status_byte, psl_r);
        chk("psu", q[0].upper_status_byte, psu_r);
        chk("unknown", q[0].unk, unknown_r);
        void'(q.pop_front());
      end
    end
  task automatic put(input logic [2:0] i, input logic [7:0] d);
    ext_wr = 1;
    ext_idx = i;
    ext_data = d;
    if (i < 3'd7)
      ex_regs[i] = d;
    @(negedge clock);
    ext_wr = 0;
    @(negedge clock);
  endtask
  task automatic issue(input logic [7:0] op, input logic [7:0] b1);
    note_t n;
    logic [14:0] a_v;
    logic [7:0] v, m, r, ix;
    logic lf, cin;
    int ri, k;
    a_v = 15'($urandom);
    m = a_v[7:0] ^ {1'b0, a_v[14:8]};
    ri = (op[1:0] == 2'd0) ? 0 : int'(op[1:0]) + (ex_psl[exec_pkg::PSL_RS] ? 3 : 0);
    ix = ex_regs[ri];
    if ((op[7:2] == exec_pkg::CLS_XOR_ABSOLUTE || op[7:2] == exec_pkg::CLS_CMP_ABSOLUTE) && b1[6:5] != 2'd0)
      ri = 0;
    v = ex_regs[ri];
    n.unk = 0;
    n.when = 6;
    if (op == exec_pkg::OPC_LOAD_UPPER)
      ex_psu = ex_regs[0] & ~exec_pkg::PSU_UNUSED_MASK;
    else if (op == exec_pkg::OPC_LOAD_LOWER)
      ex_psl = ex_regs[0];
    else if (op == exec_pkg::OPC_STORE_UPPER || op == exec_pkg::OPC_STORE_LOWER)
    begin
      ex_regs[0] = op[0] ? ex_psl : ex_psu;
      ex_psl[7:6] = cc_of(ex_regs[0]);
    end
    else
      case (op[7:2])
        exec_pkg::CLS_XOR_RELATIVE, exec_pkg::CLS_XOR_ABSOLUTE:
        begin
          ex_regs[ri] = v ^ m;
          ex_psl[7:6] = cc_of(v ^ m);
          n.when = (op[2] ? 12 : 9) + (b1[7] ? 6 : 0);
        end
        exec_pkg::CLS_CMP_REG_ZERO: ex_psl[7:6] = cmp_cc(ex_regs[0], v, ex_psl[exec_pkg::PSL_COM]);
        exec_pkg::CLS_CMP_IMM: ex_psl[7:6] = cmp_cc(v, b1, ex_psl[exec_pkg::PSL_COM]);
        exec_pkg::CLS_CMP_RELATIVE, exec_pkg::CLS_CMP_ABSOLUTE:
        begin
          ex_psl[7:6] = cmp_cc(v, m, ex_psl[exec_pkg::PSL_COM]);
          n.when = (op[2] ? 12 : 9) + (b1[7] ? 6 : 0);
        end
        exec_pkg::CLS_ROTATE_LEFT, exec_pkg::CLS_ROTATE_RIGHT:
        begin
          lf = op[7:2] == exec_pkg::CLS_ROTATE_LEFT;
          cin = ex_psl[3] ? ex_psl[0] : (lf ? v[7] : v[0]);
          r = lf ? {v[6:0], cin} : {cin, v[7:1]};
          if (ex_psl[3])
          begin
            ex_psl[0] = lf ? v[7] : v[0];
            ex_psl[5] = lf ? v[4] : v[6];
          end
          if (r[7] != v[7])
            ex_psl[2] = 1'b1;
          ex_regs[ri] = r;
          ex_psl[7:6] = cc_of(r);
        end
        default:
        begin
          n.when = 0;
          n.unk = 1;
        end
      endcase
    n.regs = ex_regs;
    n.upper_status_byte = ex_psu;
    n.lower_status_byte = ex_psl;
    n.when = n.when + cyc + 1;
    start = 1;
    opcode = op;
    byte1 = b1;
    ea = a_v;
    q.push_back(n);
    @(negedge clock);
    chk("index value", ix, index_value_r);
    // Start while busy must be ignored
    start = !n.unk;
    opcode = 8'($urandom);
    if (n.unk)
      chk("retired", 1, done_r);
    @(negedge clock);
    if (!n.unk)
      start = 0;
    for (k = 0; k < 40 && !n.unk && done_r !== 1'b1; k++)
      @(negedge clock);
    if (!n.unk)
      chk("retired", 1, done_r);
  endtask
  initial
  begin
    int m, j;
    logic [7:0] o, s;
    void'($urandom(32'hc16107ed));
    repeat (20) @(negedge clock);
    resetn = 1;
    chk("reset regs", 0, regs_r);
    for (j = 0; j < 7; j++)
      put(3'(j), 8'($urandom));
    put(3'd7, 8'hff);
    for (m = 0; m < 24; m++)
    begin
      s = 8'($urandom);
      s[3] = m[0];
      s[1] = m[1];
      put(3'($urandom % 7), 8'($urandom));
      put(3'd0, s);
      issue(exec_pkg::OPC_LOAD_LOWER, 8'h00);
      foreach (ops[j])
      begin
        o = ops[j];
        if (j < 8)
          o[1:0] = 2'($urandom);
        slow = 1'($urandom);
        issue(o, 8'($urandom));
      end
    end
    repeat (4) @(negedge clock);
    chk("queue empty", 0, q.size());
    summarize();
  end
  initial
  begin
    #(8 * 20000);
    miscompares++;
    summarize();
  end
endmodule
